// File: design/btc_pkg.sv
// shared constants, types and helpers of the control-flow execution block
package btc_pkg;

    // ****************************************************************
    // opcodes
    // ****************************************************************
    localparam logic [7:0] BTC_OP_IDLE   = 8'h00;
    localparam logic [7:0] BTC_OP_BKPT   = 8'hFF;
    localparam logic [7:0] BTC_OP_UBE    = 8'hF9;
    localparam logic [7:0] BTC_OP_SLE    = 8'hFD;
    localparam logic [7:0] BTC_OP_SLT    = 8'hFB;
    localparam logic [7:0] BTC_OP_MINUS  = 8'hF7;
    localparam logic [7:0] BTC_OP_PLUS   = 8'hF6;
    localparam logic [7:0] BTC_OP_NZ     = 8'hF2;
    localparam logic [7:0] BTC_OP_NOVF   = 8'hF4;
    localparam logic [7:0] BTC_OP_OVF    = 8'hF5;
    localparam logic [7:0] BTC_OP_ALWAYS = 8'hFE;
    localparam logic [7:0] BTC_OP_CALL   = 8'hC5;

    // ****************************************************************
    // instruction lengths, clock counts, stack figures
    // ****************************************************************
    localparam logic [23:0] BTC_LEN_ONE   = 24'h000001;
    localparam logic [23:0] BTC_LEN_SHORT = 24'h000002;
    localparam logic [23:0] BTC_LEN_CALL  = 24'h000003;
    localparam logic [4:0]  BTC_CLK_TAKEN   = 5'h06;
    localparam logic [4:0]  BTC_CLK_NTAKEN  = 5'h03;
    localparam logic [4:0]  BTC_CLK_BKPT    = 5'h17;
    localparam logic [4:0]  BTC_CLK_BKPT_PZ = 5'h13;
    localparam logic [4:0]  BTC_CLK_CALL    = 5'h07;
    localparam logic [4:0]  BTC_CLK_CALL_PZ = 5'h04;
    localparam logic [4:0]  BTC_CLK_IDLE    = 5'h03;
    localparam logic [4:0]  BTC_CLK_BAD     = 5'h01;
    localparam logic [15:0] BTC_DROP_BKPT   = 16'h0006;
    localparam logic [15:0] BTC_DROP_CALL   = 16'h0004;
    localparam logic [15:0] BTC_DROP_PZ     = 16'h0002;
    localparam logic [15:0] BTC_STACK_STEP  = 16'h0002;
    localparam logic [1:0]  BTC_PUSH_BKPT   = 2'h3;
    localparam logic [1:0]  BTC_PUSH_CALL   = 2'h2;
    localparam logic [1:0]  BTC_PUSH_PZ     = 2'h1;
    localparam logic [15:0] BTC_SYS_MODE    = 16'h8000;
    localparam logic [7:0]  BTC_PAGE_CLEAR  = 8'h00;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] disp;    // short form uses the low byte only
    } btc_instr_t;

    typedef struct packed {
        logic c;
        logic v;
        logic n;
        logic z;
    } btc_flags_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [15:0] data;
    } btc_push_t;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [23:0] btc_sext8(input logic [7:0] d);
        return {{16{d[7]}}, d};
    endfunction

    function automatic logic [23:0] btc_sext16(input logic [15:0] d);
        return {{8{d[15]}}, d};
    endfunction

    // base plus twice the offset, forced to a word boundary
    function automatic logic [23:0] btc_rel_target(
        input logic [23:0] base,
        input logic [23:0] offs);
        logic [23:0] sum;
        sum = base + {offs[22:0], 1'b0};
        return {sum[23:1], 1'b0};
    endfunction

endpackage

// File: design/btc_branch_unit.sv
// condition evaluation and target arithmetic for short branches and call
`timescale 1ns/100ps
`default_nettype none
module btc_branch_unit
    import btc_pkg::*;
(
    // instruction and machine state
    input  wire btc_instr_t  i_instr,
    input  wire btc_flags_t  i_flags,
    input  wire logic [23:0] i_pc,
    // results
    output logic             o_known,
    output logic             o_taken,
    output logic [23:0]      o_next_pc
);
    logic [7:0]  op;
    logic        is_call;
    logic [23:0] fall;
    logic [23:0] offs;
    logic        cond;

    // fall-through address: pc advances before any target is formed
    assign op      = i_instr.opcode;
    assign is_call = (op == BTC_OP_CALL);
    assign fall    = i_pc + (is_call ? BTC_LEN_CALL : BTC_LEN_SHORT);
    // displacements are two's complement
    assign offs    = is_call ? btc_sext16(i_instr.disp)
                             : btc_sext8(i_instr.disp[7:0]);

    // per-opcode branch conditions
    assign cond =
        (op == BTC_OP_UBE    && (i_flags.z | i_flags.c))
      | (op == BTC_OP_SLE    && ((i_flags.z | i_flags.n) ^ i_flags.v))
      | (op == BTC_OP_SLT    && (i_flags.n ^ i_flags.v))
      | (op == BTC_OP_MINUS  && i_flags.n)
      | (op == BTC_OP_PLUS   && !i_flags.n)
      | (op == BTC_OP_NZ     && !i_flags.z)
      | (op == BTC_OP_NOVF   && !i_flags.v)
      | (op == BTC_OP_OVF    && i_flags.v)
      | (op == BTC_OP_ALWAYS) | is_call;

    assign o_known = (op == BTC_OP_UBE) || (op == BTC_OP_SLE)
                  || (op == BTC_OP_SLT) || (op == BTC_OP_MINUS)
                  || (op == BTC_OP_PLUS) || (op == BTC_OP_NZ)
                  || (op == BTC_OP_NOVF) || (op == BTC_OP_OVF)
                  || (op == BTC_OP_ALWAYS) || is_call;
    assign o_taken   = cond;
    assign o_next_pc = cond ? btc_rel_target(fall, offs) : fall;
endmodule // btc_branch_unit
`default_nettype wire

// File: design/btc_control.sv
// control-flow execution: breakpoint trap, short branches, long call
// How it works
// - opcode FFh decodes as breakpoint trap, so blank memory traps.
// - opcode 00h decodes as the idle operation.
// - breakpoint acts as immediate interrupt: vector fetched, system mode.
// - breakpoint: pc plus one, system stack drops six, pc and status pushed.
// - breakpoint loads status and pc low from vector; pc 23..16, bit0 cleared.
// - breakpoint is one byte, 23 clocks, 19 in page zero mode.
// - short branch: pc plus two, taken adds twice displacement, bit0 clear.
// - conditional short branches: two bytes, 6 clocks taken, 3 not.
// - unsigned below-equal taken when zero or carry is set.
// - signed less-equal taken when (zero or negative) xor overflow.
// - signed less-than taken when negative xor overflow.
// - minus taken on negative set; plus taken on negative clear.
// - nonzero branch taken when the zero flag is clear.
// - no-overflow taken on overflow clear; overflow on overflow set.
// - always-jump: pc plus two plus twice displacement, bit0 clear, 6 clocks.
// - long call: pc plus three, stack drops four, 24-bit return pushed.
// - in page zero mode the long call pushes only 16 return bits.
`timescale 1ns/100ps
`default_nettype none
module btc_control
    import btc_pkg::*;
(
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    // instruction request
    input  wire logic        I_START,
    input  wire btc_instr_t  I_INSTR,
    // machine state at issue
    input  wire btc_flags_t  I_FLAGS,
    input  wire logic [23:0] I_PC,
    input  wire logic [15:0] I_SP,
    input  wire logic [15:0] I_SSP,
    input  wire logic [15:0] I_STATUS,
    input  wire logic        I_PAGE_ZERO,
    // breakpoint vector words from code memory
    input  wire logic [15:0] I_VEC_STATUS,
    input  wire logic [15:0] I_VEC_TARGET,
    // handshake
    output logic             O_BUSY,
    output logic             O_DONE,
    // results
    output logic [23:0]      O_PC,
    output logic [15:0]      O_SP,
    output logic [15:0]      O_SSP,
    output logic [15:0]      O_STATUS,
    output logic             O_STATUS_LOAD,
    output logic             O_SYS_MODE,
    output logic             O_ILLEGAL,
    // stack writes
    output btc_push_t        O_PUSH
);

    // ****************************************************************
    // state and decode
    // ****************************************************************
    typedef enum logic {BTC_WAIT, BTC_RUN} btc_state_t;

    btc_state_t  state;
    btc_state_t  next_state;
    logic [4:0]  cnt;
    logic [4:0]  next_cnt;
    logic        accept;
    logic [7:0]  op;
    logic        is_bkpt;
    logic        is_idle;
    logic        is_call;
    logic        br_known;
    logic        br_taken;
    logic [23:0] br_pc;
    logic        known;
    logic [4:0]  cycles;
    logic [23:0] bkpt_ret;
    logic [23:0] call_ret;
    logic [15:0] ssp_new;
    logic [15:0] sp_new;
    logic [23:0] next_pc;
    logic [15:0] push_word [0:2];
    logic [1:0]  push_num;
    logic [1:0]  push_idx;
    logic [15:0] push_base;

    // requests are taken only while idle
    assign accept  = I_START && (state == BTC_WAIT);
    assign op      = I_INSTR.opcode;
    assign is_bkpt = (op == BTC_OP_BKPT);
    assign is_idle = (op == BTC_OP_IDLE);
    assign is_call = (op == BTC_OP_CALL);
    assign known   = br_known || is_bkpt || is_idle;
    assign O_BUSY  = (state == BTC_RUN);
    assign O_DONE  = (state == BTC_RUN) && (cnt == 5'h00);

    // ****************************************************************
    // branch condition and target
    // ****************************************************************
    btc_branch_unit u_branch (
        .i_instr   (I_INSTR),
        .i_flags   (I_FLAGS),
        .i_pc      (I_PC),
        .o_known   (br_known),
        .o_taken   (br_taken),
        .o_next_pc (br_pc)
    );

    // ****************************************************************
    // cycle budget per instruction
    // ****************************************************************
    // page zero shortens trap and call; only the call stacks less
    assign cycles =
        is_bkpt  ? (I_PAGE_ZERO ? BTC_CLK_BKPT_PZ : BTC_CLK_BKPT)
      : is_call  ? (I_PAGE_ZERO ? BTC_CLK_CALL_PZ : BTC_CLK_CALL)
      : is_idle  ? BTC_CLK_IDLE
      : !br_known ? BTC_CLK_BAD
      : br_taken ? BTC_CLK_TAKEN
      : BTC_CLK_NTAKEN;

    // ****************************************************************
    // stack and program counter arithmetic
    // ****************************************************************
    assign bkpt_ret = I_PC + BTC_LEN_ONE;
    assign call_ret = I_PC + BTC_LEN_CALL;
    assign ssp_new  = I_SSP - BTC_DROP_BKPT;
    assign sp_new   = I_SP - (I_PAGE_ZERO ? BTC_DROP_PZ
                                          : BTC_DROP_CALL);
    // vector target: page byte and bit 0 forced to zero
    assign next_pc  =
        is_bkpt ? {BTC_PAGE_CLEAR, I_VEC_TARGET[15:1], 1'b0}
      : is_idle ? I_PC + BTC_LEN_ONE
      : br_known ? br_pc
      : I_PC;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    assign next_state = accept ? BTC_RUN
                      : (O_DONE ? BTC_WAIT : state);
    assign next_cnt   = accept ? cycles - 5'h01
                      : (O_BUSY ? cnt - 5'h01 : cnt);

    // one run state; the counter alone sets the length
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state <= BTC_WAIT;
            cnt   <= 5'h00;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ****************************************************************
    // results, captured when the request is taken
    // ****************************************************************
    // outputs settle one edge after issue and hold until the next issue
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_PC          <= 24'h000000;
            O_SP          <= 16'h0000;
            O_SSP         <= 16'h0000;
            O_STATUS      <= 16'h0000;
            O_STATUS_LOAD <= 1'b0;
            O_SYS_MODE    <= 1'b0;
            O_ILLEGAL     <= 1'b0;
        end else if (accept) begin
            O_PC          <= next_pc;
            O_SP          <= is_call ? sp_new : I_SP;
            O_SSP         <= is_bkpt ? ssp_new : I_SSP;
            // handler always starts in system mode, whatever the vector
            O_STATUS      <= is_bkpt ? (I_VEC_STATUS | BTC_SYS_MODE)
                                     : I_STATUS;
            O_STATUS_LOAD <= is_bkpt;
            O_SYS_MODE    <= is_bkpt;
            O_ILLEGAL     <= !known;
        end
    end

    // ****************************************************************
    // stack write list
    // ****************************************************************
    // trap frame: status lowest, then pc low, then pc page
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            push_num  <= 2'h0;
            push_base <= 16'h0000;
            push_word[0] <= 16'h0000;
            push_word[1] <= 16'h0000;
            push_word[2] <= 16'h0000;
        end else if (accept && is_bkpt) begin
            push_num     <= BTC_PUSH_BKPT;
            push_base    <= ssp_new;
            push_word[0] <= I_STATUS;
            push_word[1] <= bkpt_ret[15:0];
            push_word[2] <= {BTC_PAGE_CLEAR, bkpt_ret[23:16]};
        end else if (accept && is_call) begin
            push_num     <= I_PAGE_ZERO ? BTC_PUSH_PZ
                                        : BTC_PUSH_CALL;
            push_base    <= sp_new;
            push_word[0] <= call_ret[15:0];
            push_word[1] <= {BTC_PAGE_CLEAR, call_ret[23:16]};
            push_word[2] <= 16'h0000;
        end else if (accept) begin
            push_num <= 2'h0;
        end
    end

    // one word per cycle; every budget leaves room for its pushes
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            push_idx <= 2'h0;
            O_PUSH   <= '0;
        end else if (accept) begin
            push_idx <= 2'h0;
            O_PUSH   <= '0;
        end else if (O_BUSY && push_idx < push_num) begin
            push_idx    <= push_idx + 2'h1;
            O_PUSH.we   <= 1'b1;
            O_PUSH.addr <= push_base + (BTC_STACK_STEP * push_idx);
            O_PUSH.data <= push_word[push_idx];
        end else begin
            O_PUSH.we <= 1'b0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    property p_bkpt_time;
        accept && is_bkpt && !I_PAGE_ZERO |-> ##23 O_DONE;
    endproperty
    a_bkpt_time: assert property (p_bkpt_time)
        else $error("breakpoint did not finish in 23 clocks");

    property p_bkpt_time_pz;
        accept && is_bkpt && I_PAGE_ZERO
            |-> !O_DONE [*8] ##12 O_DONE;
    endproperty
    a_bkpt_time_pz: assert property (p_bkpt_time_pz)
        else $error("page zero breakpoint not 19 clocks");

    property p_bkpt_frame;
        accept && is_bkpt |=> O_SSP == $past(I_SSP) - 16'h0006
            && O_PC[23:16] == 8'h00 && !O_PC[0] && O_SYS_MODE;
    endproperty
    a_bkpt_frame: assert property (p_bkpt_frame)
        else $error("breakpoint frame or vector load wrong");

    property p_bkpt_pushes;
        accept && is_bkpt |-> ##2 O_PUSH.we [*3] ##1 !O_PUSH.we;
    endproperty
    a_bkpt_pushes: assert property (p_bkpt_pushes)
        else $error("breakpoint did not push three words");

    property p_taken_time;
        accept && br_known && !is_call && br_taken |-> ##6 O_DONE;
    endproperty
    a_taken_time: assert property (p_taken_time)
        else $error("taken branch not 6 clocks");

    property p_ntaken_time;
        accept && br_known && !br_taken |-> ##2 !O_DONE ##1 O_DONE;
    endproperty
    a_ntaken_time: assert property (p_ntaken_time)
        else $error("untaken branch not 3 clocks");

    property p_ube_pc;
        accept && op == BTC_OP_UBE && (I_FLAGS.z | I_FLAGS.c)
            |=> O_PC == btc_rel_target($past(I_PC) + 24'h000002,
                         btc_sext8($past(I_INSTR.disp[7:0])));
    endproperty
    a_ube_pc: assert property (p_ube_pc)
        else $error("below-equal branch target wrong");

    property p_sle_fall;
        accept && op == BTC_OP_SLE
            && !((I_FLAGS.z | I_FLAGS.n) ^ I_FLAGS.v)
            |=> O_PC == $past(I_PC) + 24'h000002;
    endproperty
    a_sle_fall: assert property (p_sle_fall)
        else $error("less-equal branch taken wrongly");

    property p_call_pz;
        accept && is_call && I_PAGE_ZERO
            |=> O_SP == $past(I_SP) - 16'h0002 ##1 O_PUSH.we
                ##1 !O_PUSH.we;
    endproperty
    a_call_pz: assert property (p_call_pz)
        else $error("page zero call pushed wrong amount");

    property p_call_sp;
        accept && is_call && !I_PAGE_ZERO
            |=> O_SP == $past(I_SP) - 16'h0004 && !O_PC[0];
    endproperty
    a_call_sp: assert property (p_call_sp)
        else $error("call stack drop or target wrong");

    c_bkpt:   cover property (accept && is_bkpt);
    c_call:   cover property (accept && is_call && !I_PAGE_ZERO);
    c_taken:  cover property (accept && br_taken && !is_call);
    c_ntaken: cover property (accept && br_known && !br_taken);

endmodule // btc_control
`default_nettype wire

// File: tb/test_branch_trap_call_control.sv
// self-checking testbench of the control-flow execution block
`timescale 1ns/100ps
`default_nettype none
module test_branch_trap_call_control
    import btc_pkg::*;
;
    // ****************************************************************
    // stimulus signals and bookkeeping
    // ****************************************************************
    typedef struct packed {
        logic [23:0] pc;
        logic [15:0] sp;
        logic [15:0] system_stack_ptr;
        logic [15:0] st;
        logic        sl;
        logic        ill;
        logic        pcchk;
        logic [4:0]  cyc;
    } btc_note_t;

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        start = 1'b0;
    btc_instr_t  instr = '0;
    btc_flags_t  flags = '0;
    logic [23:0] pc = '0;
    logic [15:0] sp = '0;
    logic [15:0] system_stack_ptr = '0;
    logic [15:0] status = '0;
    logic        page_zero = 1'b0;
    logic [15:0] vec_status = '0;
    logic [15:0] vec_target = '0;
    logic        busy, done, status_load, sys_mode, illegal;
    logic [23:0] o_pc;
    logic [15:0] o_sp, o_ssp, o_status;
    btc_push_t   push_w;
    btc_note_t   noteq [$];
    logic [31:0] pushq [$];
    btc_note_t   cur;
    logic [31:0] pexp;
    logic [31:0] rv;
    int          busy_n = 0;
    int          bad_count = 0;
    int          total_checks = 0;
    logic [7:0]  br_ops [10] = '{BTC_OP_UBE, BTC_OP_SLE, BTC_OP_SLT,
        BTC_OP_MINUS, BTC_OP_PLUS, BTC_OP_NZ, BTC_OP_NOVF, BTC_OP_OVF,
        BTC_OP_ALWAYS, BTC_OP_BKPT};

    always #10 clk = ~clk;

    btc_control u_btc_control (
        .I_CLK         (clk),
        .I_RESET       (reset),
        .I_START       (start),
        .I_INSTR       (instr),
        .I_FLAGS       (flags),
        .I_PC          (pc),
        .I_SP          (sp),
        .I_SSP         (system_stack_ptr),
        .I_STATUS      (status),
        .I_PAGE_ZERO   (page_zero),
        .I_VEC_STATUS  (vec_status),
        .I_VEC_TARGET  (vec_target),
        .O_BUSY        (busy),
        .O_DONE        (done),
        .O_PC          (o_pc),
        .O_SP          (o_sp),
        .O_SSP         (o_ssp),
        .O_STATUS      (o_status),
        .O_STATUS_LOAD (status_load),
        .O_SYS_MODE    (sys_mode),
        .O_ILLEGAL     (illegal),
        .O_PUSH        (push_w)
    );

    // ****************************************************************
    // comparison and verdict
    // ****************************************************************
    task automatic check(input logic [47:0] seen, input logic [47:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // branch condition worked out from the flags {c,v,n,z}
    function automatic logic cond(input logic [7:0] op, input logic [3:0] f);
        case (op)
            BTC_OP_UBE:   return f[0] | f[3];
            BTC_OP_SLE:   return (f[0] | f[1]) ^ f[2];
            BTC_OP_SLT:   return f[1] ^ f[2];
            BTC_OP_MINUS: return f[1];
            BTC_OP_PLUS:  return ~f[1];
            BTC_OP_NZ:    return ~f[0];
            BTC_OP_NOVF:  return ~f[2];
            BTC_OP_OVF:   return f[2];
            default:      return 1'b1;
        endcase
    endfunction

    // ****************************************************************
    // driver: one instruction, expectation noted before the take
    // ****************************************************************
    task automatic issue(input logic [7:0] op, input logic [15:0] d,
                         input logic [3:0] f, input logic pz,
                         input logic poke);
        logic [31:0] r1, r2, r3, r4;
        logic [23:0] ret;
        btc_note_t   n;
        int          k;
        r1 = $urandom;
        r2 = $urandom;
        r3 = $urandom;
        r4 = $urandom;
        n = '{pc: r1[23:0] + 24'h000002, sp: r2[15:0], system_stack_ptr: r2[31:16],
              st: r3[15:0], sl: 1'b0, ill: 1'b0, pcchk: 1'b1, cyc: 5'h03};
        case (op)
            BTC_OP_BKPT: begin
                ret = r1[23:0] + 24'h000001;
                n.pc = {8'h00, r3[31:17], 1'b0};
                n.system_stack_ptr = r2[31:16] - 16'h0006;
                n.st = r4[15:0] | 16'h8000;
                n.sl = 1'b1;
                n.cyc = pz ? 5'h13 : 5'h17;
                pushq.push_back({n.system_stack_ptr, r3[15:0]});
                pushq.push_back({n.system_stack_ptr + 16'h0002, ret[15:0]});
                pushq.push_back({n.system_stack_ptr + 16'h0004, 8'h00, ret[23:16]});
            end
            BTC_OP_CALL: begin
                ret = r1[23:0] + 24'h000003;
                n.pc = (ret + {{7{d[15]}}, d, 1'b0}) & 24'hFFFFFE;
                n.sp = r2[15:0] - (pz ? 16'h0002 : 16'h0004);
                n.cyc = pz ? 5'h04 : 5'h07;
                pushq.push_back({n.sp, ret[15:0]});
                if (!pz)
                    pushq.push_back({n.sp + 16'h0002, 8'h00, ret[23:16]});
            end
            BTC_OP_IDLE: n.pc = r1[23:0] + 24'h000001;
            8'h12: begin
                n.pc = r1[23:0];
                n.ill = 1'b1;
                n.cyc = 5'h01;
            end
            default: if (cond(op, f)) begin
                n.pc = (n.pc + {{15{d[7]}}, d[7:0], 1'b0}) & 24'hFFFFFE;
                n.cyc = 5'h06;
            end
        endcase
        @(posedge clk);
        #2;
        instr = btc_instr_t'({op, d});
        flags = btc_flags_t'(f);
        pc = r1[23:0];
        sp = r2[15:0];
        system_stack_ptr = r2[31:16];
        status = r3[15:0];
        vec_target = r3[31:16];
        vec_status = r4[15:0];
        page_zero = pz;
        start = 1'b1;
        noteq.push_back(n);
        @(posedge clk);
        #2;
        start = 1'b0;
        // a second request while busy must leave no trace
        if (poke) begin
            @(posedge clk);
            #2;
            start = 1'b1;
            instr = btc_instr_t'({BTC_OP_CALL, d});
            @(posedge clk);
            #2;
            start = 1'b0;
        end
        k = 0;
        while (busy !== 1'b0 && k < 40) begin
            @(posedge clk);
            #2;
            k++;
        end
        if (k >= 40) begin
            bad_count++;
            conclude();
        end
    endtask

    // ****************************************************************
    // watcher: outputs sampled mid-cycle, matched to the oldest note
    // ****************************************************************
    always @(negedge clk) begin
        if (reset) begin
            busy_n = 0;
        end else begin
            if (push_w.we === 1'b1) begin
                pexp = (pushq.size() != 0) ? pushq.pop_front() : 32'hX;
                check(48'({push_w.addr, push_w.data}), 48'(pexp), "push");
            end
            if (busy === 1'b1)
                busy_n++;
            if (done === 1'b1) begin
                cur = (noteq.size() != 0) ? noteq.pop_front() : 'X;
                if (cur.pcchk)
                    check(48'(o_pc), 48'(cur.pc), "pc");
                check(48'(o_sp), 48'(cur.sp), "sp");
                check(48'(o_ssp), 48'(cur.system_stack_ptr), "ssp");
                check(48'(o_status), 48'(cur.st), "status");
                check(48'(status_load), 48'(cur.sl), "load");
                check(48'(sys_mode), 48'(cur.sl), "sysmode");
                check(48'(illegal), 48'(cur.ill), "illegal");
                check(48'(busy_n), 48'(cur.cyc), "clocks");
                busy_n = 0;
            end
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rv = $urandom(32'h7CCC1565);
        repeat (16) @(posedge clk);
        #2;
        reset = 1'b0;
        issue(BTC_OP_BKPT, 16'h0000, 4'hF, 1'b0, 1'b1);
        issue(BTC_OP_BKPT, 16'h0000, 4'h0, 1'b1, 1'b0);
        issue(BTC_OP_CALL, 16'h7FFF, 4'h0, 1'b0, 1'b0);
        issue(BTC_OP_CALL, 16'h8000, 4'h0, 1'b0, 1'b0);
        issue(BTC_OP_CALL, 16'h8001, 4'h0, 1'b1, 1'b0);
        issue(BTC_OP_IDLE, 16'h0000, 4'h0, 1'b0, 1'b0);
        issue(8'h12, 16'h0000, 4'h0, 1'b0, 1'b0);
        issue(BTC_OP_ALWAYS, 16'h007F, 4'h0, 1'b0, 1'b0);
        issue(BTC_OP_ALWAYS, 16'h0080, 4'h0, 1'b1, 1'b0);
        // every branch against every flag combination
        for (int i = 0; i < 9; i++) begin
            for (int f = 0; f < 16; f++) begin
                rv = $urandom;
                issue(br_ops[i], rv[15:0], 4'(f), rv[16], 1'b0);
            end
        end
        repeat (4) @(posedge clk);
        check(48'(noteq.size()), 48'h0, "notes left");
        check(48'(pushq.size()), 48'h0, "pushes left");
        conclude();
    end

endmodule // test_branch_trap_call_control
`default_nettype wire
